// *** design/irq_collector.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_collector (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire irq_collector_pkg::wb_request_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Event sources
  input wire logic timer0_event_i,
  input wire logic timer1_event_i,
  input wire logic host_mcu_event_i,
  input wire logic [7:0] port0_pin_i,
  input wire irq_collector_pkg::two_wire_event_t two_wire_event_i,
  // Two-wire slave configuration and status read pulse
  output logic [7:0] serial_transmit_byte_o,
  output logic [7:0] serial_mode_o,
  output logic two_wire_status_read_o,
  // Core request
  output logic irq_o
);
  import irq_collector_pkg::*;

  logic [4:0] interrupt_enable_reg;
  logic [4:0] interrupt_pending_reg;
  logic [4:0] interrupt_pending_next;
  logic [7:0] port0_pin_mask_reg;
  logic [7:0] port0_edge_polarity_reg;
  logic [7:0] port0_pin_status_reg;
  logic [7:0] port0_pin_status_next;
  logic [7:0] pin_edge;
  logic [7:0] pin_hit;
  logic [7:0] serial_status;
  logic [7:0] serial_receive_byte;
  logic two_wire_complete;
  logic [4:0] source_event;
  logic [13:0] reg_index;
  logic access;
  logic wr;
  logic rd;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic mapped;

  // Bus decode: one access per request, answered by a one-cycle ack.
  assign reg_index = wb_i.adr[15:2];
  assign access = wb_i.cyc & wb_i.stb & ~wb_ack_o;
  assign wr = access & wb_i.we & wb_i.sel[0];
  assign rd = access & ~wb_i.we;
  assign wr_byte = wb_i.dat[7:0];

  pin_edge_detect u_pin_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port0_pin_i),
    .rising_i(port0_edge_polarity_reg),
    .edge_o(pin_edge)
  );

  serial_event_capture u_serial (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(two_wire_event_i),
    .status_read_i(two_wire_status_read_o),
    .status_o(serial_status),
    .rx_byte_o(serial_receive_byte),
    .complete_o(two_wire_complete)
  );

  assign pin_hit = pin_edge & port0_pin_mask_reg;

  assign source_event[SRC_TIMER0] = timer0_event_i;
  assign source_event[SRC_TIMER1] = timer1_event_i;
  assign source_event[SRC_PORT0] = |pin_hit;
  assign source_event[SRC_HOST_MCU] = host_mcu_event_i;
  assign source_event[SRC_TWO_WIRE] = two_wire_complete;

  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    case (reg_index)
      IDX_INTERRUPT_ENABLE: rd_byte = {3'h0, interrupt_enable_reg};
      IDX_INTERRUPT_PENDING: rd_byte = {3'h0, interrupt_pending_reg};
      IDX_PORT0_PIN_MASK: rd_byte = port0_pin_mask_reg;
      IDX_PORT0_EDGE_POLARITY: rd_byte = port0_edge_polarity_reg;
      IDX_PORT0_PIN_STATUS: rd_byte = port0_pin_status_reg;
      IDX_SERIAL_MODE: rd_byte = serial_mode_o;
      IDX_SERIAL_STATUS: rd_byte = serial_status;
      IDX_SERIAL_TRANSMIT_BYTE: rd_byte = 8'h00;
      IDX_SERIAL_RECEIVE_BYTE: rd_byte = serial_receive_byte;
      default: mapped = 1'b0;
    endcase
  end

  // Ack and read data; unmapped addresses answer zero and ignore writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (rd) begin
        wb_dat_o <= {24'h00_0000, mapped ? rd_byte : 8'h00};
      end
    end
  end

  // Reading serial status clears its completion flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      two_wire_status_read_o <= 1'b0;
    end else begin
      two_wire_status_read_o <= rd & (reg_index == IDX_SERIAL_STATUS);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_enable_reg <= RST_INTERRUPT_ENABLE;
    end else if (wr && reg_index == IDX_INTERRUPT_ENABLE) begin
      interrupt_enable_reg <= wr_byte[4:0];
    end
  end

  always_comb begin
    interrupt_pending_next = interrupt_pending_reg;
    if (wr && reg_index == IDX_INTERRUPT_PENDING) begin
      interrupt_pending_next = interrupt_pending_reg & wr_byte[4:0];
    end
    interrupt_pending_next = interrupt_pending_next | source_event;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_pending_reg <= RST_INTERRUPT_PENDING;
    end else begin
      interrupt_pending_reg <= interrupt_pending_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_pin_mask_reg <= RST_BYTE;
    end else if (wr && reg_index == IDX_PORT0_PIN_MASK) begin
      port0_pin_mask_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_edge_polarity_reg <= RST_BYTE;
    end else if (wr && reg_index == IDX_PORT0_EDGE_POLARITY) begin
      port0_edge_polarity_reg <= wr_byte;
    end
  end

  always_comb begin
    port0_pin_status_next = port0_pin_status_reg;
    if (wr && reg_index == IDX_PORT0_PIN_STATUS) begin
      port0_pin_status_next = port0_pin_status_reg & wr_byte;
    end
    port0_pin_status_next = port0_pin_status_next | pin_hit;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_pin_status_reg <= RST_BYTE;
    end else begin
      port0_pin_status_reg <= port0_pin_status_next;
    end
  end

  // Serial mode register: ack enable, general call enable and device ID.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_mode_o <= RST_BYTE;
    end else if (wr && reg_index == IDX_SERIAL_MODE) begin
      serial_mode_o <= wr_byte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_transmit_byte_o <= RST_BYTE;
    end else if (wr && reg_index == IDX_SERIAL_TRANSMIT_BYTE) begin
      serial_transmit_byte_o <= wr_byte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(interrupt_pending_next & interrupt_enable_reg);
    end
  end

  // The request follows the next pending value and the enable register one cycle later.
  a_irq_follows_pending: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == |($past(interrupt_pending_next) & $past(interrupt_enable_reg)))
    else $error("irq output does not follow pending and enable");

  a_irq_single_entry: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (irq_o && !$past(rst_i)) |-> $past(|(interrupt_pending_next & interrupt_enable_reg)))
    else $error("irq raised without an enabled pending source");

  a_pending_clear_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && reg_index == IDX_INTERRUPT_PENDING && !wr_byte[SRC_TIMER0] && !timer0_event_i)
    |=> !interrupt_pending_reg[SRC_TIMER0])
    else $error("write of zero did not clear timer 0 pending");

  a_pending_write_one: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && reg_index == IDX_INTERRUPT_PENDING && wr_byte[4:0] == 5'h1f && !(|source_event))
    |=> interrupt_pending_reg == $past(interrupt_pending_reg))
    else $error("write of one changed a pending flag");

  a_pending_set_wins: assert property (
    @(posedge clk_i) disable iff (rst_i)
    timer1_event_i |=> interrupt_pending_reg[SRC_TIMER1])
    else $error("timer 1 event lost");

  a_enable_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && reg_index == IDX_INTERRUPT_ENABLE) |=> interrupt_enable_reg == $past(wr_byte[4:0]))
    else $error("enable register did not take the written value");

  a_pin_mask_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (|(pin_edge & ~port0_pin_mask_reg) && !(|pin_hit)
      && !(wr && reg_index == IDX_PORT0_PIN_STATUS))
    |=> port0_pin_status_reg == $past(port0_pin_status_reg))
    else $error("masked pin edge raised an event");

  a_pin_status_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (|pin_hit) |=> ((port0_pin_status_reg & $past(pin_hit)) == $past(pin_hit))
      && interrupt_pending_reg[SRC_PORT0])
    else $error("pin edge not recorded in status or pending");

  a_serial_source: assert property (
    @(posedge clk_i) disable iff (rst_i)
    two_wire_event_i.data_write_done |-> ##1 two_wire_complete ##1 interrupt_pending_reg[SRC_TWO_WIRE])
    else $error("two-wire completion did not raise its pending flag");

  a_serial_complete_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    two_wire_event_i.id_read_done |=> serial_status[SST_COMPLETE])
    else $error("serial completion flag not set");

  a_serial_direction: assert property (
    @(posedge clk_i) disable iff (rst_i)
    two_wire_event_i.id_read_done |=>
      serial_status[SST_DIRECTION] == $past(two_wire_event_i.read_direction))
    else $error("serial direction flag wrong");

  a_transmit_byte: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && reg_index == IDX_SERIAL_TRANSMIT_BYTE) |=> serial_transmit_byte_o == $past(wr_byte))
    else $error("transmit byte not loaded");

  a_receive_byte: assert property (
    @(posedge clk_i) disable iff (rst_i)
    two_wire_event_i.rx_valid |=> serial_receive_byte == $past(two_wire_event_i.rx_data))
    else $error("receive byte not captured");

  a_ack_one_cycle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  a_ack_answers: assert property (
    @(posedge clk_i) disable iff (rst_i)
    access |=> wb_ack_o)
    else $error("bus request not acknowledged in one cycle");

  a_polarity_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && reg_index == IDX_PORT0_EDGE_POLARITY)
    |=> port0_edge_polarity_reg == $past(wr_byte))
    else $error("polarity register did not take the written value");

  a_mask_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && reg_index == IDX_PORT0_PIN_MASK) |=> port0_pin_mask_reg == $past(wr_byte))
    else $error("pin mask register did not take the written value");

  a_pin_status_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && reg_index == IDX_PORT0_PIN_STATUS && !(|pin_hit))
    |=> port0_pin_status_reg == ($past(port0_pin_status_reg) & $past(wr_byte)))
    else $error("pin status write did not clear the zero bits");

  a_pending_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && reg_index == IDX_INTERRUPT_PENDING)
    |=> wb_dat_o == {27'h0, $past(interrupt_pending_reg)})
    else $error("pending read returned the wrong value");

  a_status_read_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && reg_index == IDX_SERIAL_STATUS) |=> two_wire_status_read_o)
    else $error("serial status read did not raise the clear pulse");

  a_receive_read_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && reg_index == IDX_SERIAL_RECEIVE_BYTE && !two_wire_event_i.rx_valid)
    |=> serial_receive_byte == $past(serial_receive_byte))
    else $error("receive byte changed by a bus write");

endmodule
`default_nettype wire

// *** design/irq_collector_pkg.sv ***
package irq_collector_pkg;

  localparam int unsigned SRC_COUNT = 5;
  localparam int unsigned PIN_COUNT = 8;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [13:0] IDX_INTERRUPT_ENABLE = 14'h1001;
  localparam logic [13:0] IDX_INTERRUPT_PENDING = 14'h1002;
  localparam logic [13:0] IDX_PORT0_PIN_MASK = 14'h1011;
  localparam logic [13:0] IDX_PORT0_EDGE_POLARITY = 14'h1012;
  localparam logic [13:0] IDX_PORT0_PIN_STATUS = 14'h1013;
  localparam logic [13:0] IDX_SERIAL_MODE = 14'h101c;
  localparam logic [13:0] IDX_SERIAL_STATUS = 14'h101d;
  localparam logic [13:0] IDX_SERIAL_TRANSMIT_BYTE = 14'h101e;
  localparam logic [13:0] IDX_SERIAL_RECEIVE_BYTE = 14'h101f;

  // Source bit positions shared by the enable and pending registers.
  localparam int unsigned SRC_TIMER0 = 0;
  localparam int unsigned SRC_TIMER1 = 1;
  localparam int unsigned SRC_PORT0 = 2;
  localparam int unsigned SRC_HOST_MCU = 3;
  localparam int unsigned SRC_TWO_WIRE = 4;

  // Serial status field positions.
  localparam int unsigned SST_COMPLETE = 7;
  localparam int unsigned SST_HOST_ACK = 3;
  localparam int unsigned SST_GENERAL_CALL = 2;
  localparam int unsigned SST_FIRST_DATA = 1;
  localparam int unsigned SST_DIRECTION = 0;

  // Reset values.
  localparam logic [4:0] RST_INTERRUPT_ENABLE = 5'h00;
  localparam logic [4:0] RST_INTERRUPT_PENDING = 5'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Event strobes from the two-wire slave shift logic, one cycle each.
  typedef struct packed {
    logic id_read_done;
    logic data_read_done;
    logic data_write_done;
    logic read_direction;
    logic host_ack;
    logic general_call;
    logic first_data;
    logic rx_valid;
    logic [7:0] rx_data;
  } two_wire_event_t;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [15:0] adr;
    logic [31:0] dat;
  } wb_request_t;

endpackage

// *** design/pin_edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser per pin with edge detection on the settled level.
module pin_edge_detect (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins and selection
  input wire logic [7:0] pin_i,
  input wire logic [7:0] rising_i,
  // Edge pulses
  output logic [7:0] edge_o
);
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] sync3_reg;
  logic [7:0] level_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_pin
      // A change counts once the last two stages agree.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          level_reg[g] <= 1'b0;
          edge_o[g] <= 1'b0;
        end else begin
          edge_o[g] <= 1'b0;
          if (sync2_reg[g] == sync3_reg[g] && sync3_reg[g] != level_reg[g]) begin
            level_reg[g] <= sync3_reg[g];
            edge_o[g] <= (sync3_reg[g] == rising_i[g]);
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** design/serial_event_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
// Holds the two-wire status flags and the last received byte.
module serial_event_capture (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Events and clear
  input wire irq_collector_pkg::two_wire_event_t event_i,
  input wire logic status_read_i,
  // State
  output logic [7:0] status_o,
  output logic [7:0] rx_byte_o,
  output logic complete_o
);
  import irq_collector_pkg::*;

  logic done;

  assign done = event_i.id_read_done | event_i.data_read_done | event_i.data_write_done;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= RST_BYTE;
      complete_o <= 1'b0;
    end else begin
      complete_o <= done;
      // complete flag, set wins over read clear
      if (done) begin
        status_o[SST_COMPLETE] <= 1'b1;
      end else if (status_read_i) begin
        status_o[SST_COMPLETE] <= 1'b0;
      end
      if (event_i.id_read_done) begin
        status_o[SST_DIRECTION] <= event_i.read_direction;
        status_o[SST_GENERAL_CALL] <= event_i.general_call;
      end
      if (event_i.data_read_done) begin
        status_o[SST_HOST_ACK] <= event_i.host_ack;
      end
      if (event_i.rx_valid) begin
        status_o[SST_FIRST_DATA] <= event_i.first_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_byte_o <= RST_BYTE;
    end else if (event_i.rx_valid) begin
      rx_byte_o <= event_i.rx_data;
    end
  end

endmodule
`default_nettype wire

// *** testbench/two_wire_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_wire_host_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command from the bench
  input wire logic go_i,
  input wire logic [1:0] kind_i,
  input wire logic dir_i,
  input wire logic [7:0] byte_i,
  // Events toward the collector
  output var irq_collector_pkg::two_wire_event_t event_o
);
  import irq_collector_pkg::*;
  two_wire_event_t e;
  // Qualifiers outside an event and outside reset show the inverse of their last value; in reset they are held at zero.
  always @(posedge clk_i) begin
    e = '0;
    e.read_direction = ~event_o.read_direction;
    e.general_call = ~event_o.general_call;
    e.host_ack = ~event_o.host_ack;
    e.first_data = ~event_o.first_data;
    e.rx_data = ~event_o.rx_data;
    if (go_i) begin
      case (kind_i)
        2'd0: begin
          e.id_read_done = 1'b1;
          e.read_direction = dir_i;
          e.general_call = 1'b0;
        end
        2'd1: begin
          e.data_read_done = 1'b1;
          e.host_ack = 1'b1;
        end
        default: begin
          e.data_write_done = 1'b1;
          e.rx_valid = 1'b1;
          e.first_data = 1'b1;
          e.rx_data = byte_i;
        end
      endcase
    end
    if (rst_i) begin
      e = '0;
    end
    event_o <= e;
  end
endmodule
`default_nettype wire

// *** testbench/irq_collector_with_serial_events_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module irq_collector_with_serial_events_test;
  import irq_collector_pkg::*;
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_request_t wb = '0;
  logic [2:0] pulse_v = '0;
  logic [7:0] pins = '0;
  logic go = 1'b0;
  logic [1:0] kind = '0;
  logic dir = 1'b0;
  logic [7:0] tx_byte = '0;
  two_wire_event_t ev;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] tx_o;
  logic [7:0] mode_o;
  logic irq_o;
  logic [7:0] q;
  logic stat_rd;
  logic [7:0] rd_pulses = '0;
  int failures = 0;
  int compares = 0;
  row_t rows [8] = '{'{16'h4004, 8'hff, 8'h1f}, '{16'h4008, 8'hff, 8'h00},
    '{16'h4044, 8'ha5, 8'ha5}, '{16'h4048, 8'h5a, 8'h5a}, '{16'h4078, 8'hc3, 8'h00},
    '{16'h407c, 8'h77, 8'h00}, '{16'h4000, 8'hee, 8'h00}, '{16'h4070, 8'h05, 8'h05}};
  logic [15:0] rst_adr [7] = '{16'h4004, 16'h4008, 16'h4044, 16'h4048, 16'h404c,
    16'h4074, 16'h407c};
  logic [7:0] src_bit [3] = '{8'h01, 8'h02, 8'h08};

  always #2.5 clk_i = ~clk_i;

  // Counts the clear pulses that follow serial status reads.
  always @(posedge clk_i) begin
    if (stat_rd === 1'b1) rd_pulses <= rd_pulses + 8'h01;
  end

  irq_collector dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer0_event_i(pulse_v[0]), .timer1_event_i(pulse_v[1]),
    .host_mcu_event_i(pulse_v[2]), .port0_pin_i(pins), .two_wire_event_i(ev),
    .serial_transmit_byte_o(tx_o), .serial_mode_o(mode_o), .two_wire_status_read_o(stat_rd),
    .irq_o(irq_o));
  two_wire_host_model host (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .kind_i(kind),
    .dir_i(dir), .byte_i(tx_byte), .event_o(ev));

  task automatic bus(input logic we, input logic [15:0] a, input logic [7:0] d);
    wb.cyc <= 1'b1;
    wb.stb <= 1'b1;
    wb.we <= we;
    wb.sel <= 4'hf;
    wb.adr <= a;
    wb.dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb.cyc <= 1'b0;
    wb.stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] ex);
    bus(1'b0, a, 8'h00);
    `CHK("read data", ex, q)
    `CHK("read upper", 24'h00_0000, wb_dat_o[31:8])
  endtask

  task automatic summarize();
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rst_adr[i]) rd_chk(rst_adr[i], 8'h00);
    `CHK("irq after reset", 1'b0, irq_o)
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    `CHK("transmit byte", 8'hc3, tx_o)
    `CHK("serial mode", 8'h05, mode_o)
    for (int i = 0; i < 3; i++) begin
      pulse_v[i] <= 1'b1;
      @(posedge clk_i);
      pulse_v <= '0;
      repeat (3) @(posedge clk_i);
      `CHK("irq raised", 1'b1, irq_o)
      rd_chk(16'h4008, src_bit[i]);
      bus(1'b1, 16'h4008, ~src_bit[i]);
      `CHK("irq cleared", 1'b0, irq_o)
      rd_chk(16'h4008, 8'h00);
    end
    bus(1'b1, 16'h4004, 8'h1e);
    pulse_v[0] <= 1'b1;
    @(posedge clk_i);
    pulse_v <= '0;
    repeat (3) @(posedge clk_i);
    `CHK("irq disabled", 1'b0, irq_o)
    rd_chk(16'h4008, 8'h01);
    bus(1'b1, 16'h4004, 8'h1f);
    `CHK("irq enabled", 1'b1, irq_o)
    bus(1'b1, 16'h4008, 8'hfe);
    for (int k = 0; k < 4; k++) begin
      go <= 1'b1;
      kind <= (k < 2) ? 2'd0 : 2'(k - 1);
      dir <= k[0];
      tx_byte <= 8'h30 + 8'(k);
      @(posedge clk_i);
      go <= 1'b0;
      repeat (6) @(posedge clk_i);
      `CHK("irq serial", 1'b1, irq_o)
      rd_chk(16'h4008, 8'h10);
      bus(1'b0, 16'h4074, 8'h00);
      `CHK("complete flag", 1'b1, q[7])
      if (k < 2) `CHK("direction", k[0], q[0])
      if (k == 2) `CHK("host ack", 1'b1, q[3])
      if (k == 3) `CHK("first data", 1'b1, q[1])
      bus(1'b0, 16'h4074, 8'h00);
      `CHK("complete cleared", 1'b0, q[7])
      bus(1'b1, 16'h4008, 8'hef);
      rd_chk(16'h4008, 8'h00);
    end
    rd_chk(16'h407c, 8'h33);
    bus(1'b1, 16'h4044, 8'h07);
    bus(1'b1, 16'h4048, 8'h01);
    pins <= 8'h0b;
    repeat (8) @(posedge clk_i);
    rd_chk(16'h404c, 8'h01);
    rd_chk(16'h4008, 8'h04);
    pins <= 8'h09;
    repeat (8) @(posedge clk_i);
    rd_chk(16'h404c, 8'h03);
    bus(1'b1, 16'h404c, 8'h00);
    bus(1'b1, 16'h4008, 8'hfb);
    pins <= 8'h01;
    repeat (8) @(posedge clk_i);
    rd_chk(16'h404c, 8'h00);
    `CHK("irq idle", 1'b0, irq_o)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("transmit after reset", 8'h00, tx_o)
    `CHK("mode after reset", 8'h00, mode_o)
    `CHK("irq after reset", 1'b0, irq_o)
    foreach (rst_adr[i]) rd_chk(rst_adr[i], 8'h00);
    `CHK("status read pulses", 8'h0a, rd_pulses)
    summarize();
  end
endmodule
`default_nettype wire
